//--- rtl/tab_pkg.sv
package tab_pkg;

    // ************************************************************
    // attribute encodings, ranked weakest to strongest
    // ************************************************************
    localparam logic [2:0] DEV_NORMAL = 3'h0;
    localparam logic [2:0] DEV_GRE    = 3'h1;
    localparam logic [2:0] DEV_NGRE   = 3'h2;
    localparam logic [2:0] DEV_NGNRE  = 3'h3;
    localparam logic [2:0] DEV_NGNRNE = 3'h4;
    localparam logic [1:0] CACHE_WB   = 2'h0;
    localparam logic [1:0] CACHE_WT   = 2'h1;
    localparam logic [1:0] CACHE_NC   = 2'h2;
    localparam logic [1:0] SH_NSH     = 2'h0;
    localparam logic [1:0] SH_ISH     = 2'h1;
    localparam logic [1:0] SH_OSH     = 2'h2;
    // hint triple is {read_alloc_hint, write_alloc_hint, ephemeral_hint}
    localparam logic [2:0] HINT_DEF   = 3'h6;
    localparam logic [2:0] HINT_NONE  = 3'h0;

    typedef struct packed {
        logic [2:0] dev;
        logic [1:0] ic;
        logic [1:0] oc;
        logic [1:0] sh;
        logic [2:0] hi;
        logic [2:0] ho;
    } tab_attr_t;

    typedef enum logic [1:0] {
        CLS_PLAIN,
        CLS_ATS_REQ,
        CLS_ATS_XLT,
        CLS_CMO
    } tab_class_t;

    // ************************************************************
    // supplied-mask bit positions
    // ************************************************************
    localparam int SUP_MT   = 0;
    localparam int SUP_SH   = 1;
    localparam int SUP_HINT = 2;
    localparam int SUP_INST = 3;
    localparam int SUP_ACCESS_LEVEL_MARKER = 4;
    localparam int SUP_NS   = 5;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  A_CTRL  = 8'h00;
    localparam logic [7:0]  A_GBPA  = 8'h04;
    localparam logic [7:0]  A_SGBPA = 8'h08;
    localparam logic [7:0]  A_IDR   = 8'h0C;
    localparam logic [7:0]  A_STAT  = 8'h10;
    localparam int CTRL_EN  = 0;
    localparam int CTRL_SEN = 1;
    localparam int IDR_FWB  = 0;
    localparam int IDR_SEC  = 1;
    localparam logic        FWB_SUPPORTED  = 1'b1;
    localparam logic        SECURE_PRESENT = 1'b1;

    // bypass attribute register fields
    localparam int GB_MT_SEL  = 0;
    localparam int GB_MT_VAL  = 4;
    localparam int GB_SH      = 12;
    localparam int GB_HINT    = 16;
    localparam int GB_HINT_EN = 19;
    localparam int GB_INST    = 20;
    localparam int GB_ACCESS_LEVEL_MARKER    = 22;
    localparam int GB_NS      = 24;
    localparam logic [31:0] GBPA_MASK = 32'h03FF_37F1;
    // build-time choice: pass everything through as incoming
    localparam logic [31:0] GBPA_RST  = 32'h0000_3000;
    localparam logic [31:0] SGBPA_RST = 32'h0000_3000;
    localparam logic [1:0]  CTRL_RST  = 2'h0;

endpackage

//--- rtl/tab_attr_unit.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
// Overview of operation
// - direction, fetch, level, security never merged
// - merge outputs stronger of two values
// - stage 2 merges stage 1 or incoming
// - device outranks normal; nGnRnE outranks nGnRE
// - no-allocate and transient rank stronger
// - forced writeback support bit reads 1
// - stage2 forced writeback gives normal WB shareable
// - no-snoop transactions ignore forced writeback
// - forced writeback also covers translation-op results
// - device or fully noncached become outer shareable
// - noncached level gets no-allocate, non-transient
// - cacheable no-allocate both ways is non-transient
// - clean-up also applies to translation-op results
// - disabled translation bypasses with global overrides
// - override field is fixed value or incoming
// - bypass forwards otherwise unchanged
// - cache maintenance hints normalised in bypass
// - ATS requests and translated terminated when disabled
// - enabled translation starts table lookup flow
// - stream security input selects control set
// - bypass security marker from override or incoming; one for non-secure streams
// - bypass registers reset to build-time values
// - defaults for unsupplied incoming attributes
module tab_attr_unit (
    // clock and reset
    input  wire logic                I_CLK_SYS,
    input  wire logic                I_RST,
    // register port
    input  wire logic [7:0]          I_ADDR,
    input  wire logic [31:0]         I_WDATA,
    input  wire logic                I_WR,
    input  wire logic                I_RD,
    output logic      [31:0]         O_RDATA,
    // incoming transaction
    input  wire logic                I_VALID,
    input  wire logic                I_WRITE,
    input  wire logic                I_INSTR,
    input  wire logic                I_ACCESS_LEVEL_MARKER,
    input  wire logic                I_NS,
    input  wire logic                I_SEC_STREAM,
    input  wire tab_pkg::tab_class_t I_CLASS,
    input  wire logic                I_NO_SNOOP,
    input  wire logic                I_XLAT_OP,
    input  wire logic [5:0]          I_SUPPLIED,
    input  wire logic [2:0]          I_DEV,
    input  wire logic [1:0]          I_ICACHE,
    input  wire logic [1:0]          I_OCACHE,
    input  wire logic [1:0]          I_SHARE,
    input  wire logic [2:0]          I_HINT_I,
    input  wire logic [2:0]          I_HINT_O,
    // stage 1 result
    input  wire logic                I_S1_EN,
    input  wire logic [2:0]          I_S1_DEV,
    input  wire logic [1:0]          I_S1_ICACHE,
    input  wire logic [1:0]          I_S1_OCACHE,
    input  wire logic [1:0]          I_S1_SHARE,
    input  wire logic [2:0]          I_S1_HINT_I,
    input  wire logic [2:0]          I_S1_HINT_O,
    // stage 2 result
    input  wire logic                I_S2_EN,
    input  wire logic                I_S2_FWB,
    input  wire logic [2:0]          I_S2_DEV,
    input  wire logic [1:0]          I_S2_ICACHE,
    input  wire logic [1:0]          I_S2_OCACHE,
    input  wire logic [1:0]          I_S2_SHARE,
    // outgoing transaction
    output logic                     O_VALID,
    output logic [2:0]               O_DEV,
    output logic [1:0]               O_ICACHE,
    output logic [1:0]               O_OCACHE,
    output logic [1:0]               O_SHARE,
    output logic [2:0]               O_HINT_I,
    output logic [2:0]               O_HINT_O,
    output logic                     O_INSTR,
    output logic                     O_ACCESS_LEVEL_MARKER,
    output logic                     O_NS,
    output logic                     O_BYPASS,
    output logic                     O_TERMINATE,
    output logic                     O_XLATE,
    output logic                     O_XLAT_OP
);

    // ************************************************************
    // merge and clean-up
    // ************************************************************
    function automatic tab_pkg::tab_attr_t f_comb(input tab_pkg::tab_attr_t a,
                                                  input tab_pkg::tab_attr_t b);
        tab_pkg::tab_attr_t r;
        r.dev = (a.dev > b.dev) ? a.dev : b.dev;
        r.ic  = (a.ic > b.ic) ? a.ic : b.ic;
        r.oc  = (a.oc > b.oc) ? a.oc : b.oc;
        r.sh  = (a.sh > b.sh) ? a.sh : b.sh;
        r.hi  = {a.hi[2:1] & b.hi[2:1], a.hi[0] | b.hi[0]};
        r.ho  = {a.ho[2:1] & b.ho[2:1], a.ho[0] | b.ho[0]};
        return r;
    endfunction

    function automatic logic [2:0] f_lvl(input logic [1:0] c, input logic [2:0] h);
        logic [2:0] r;
        r = h;
        if (c == tab_pkg::CACHE_NC) begin
            r = tab_pkg::HINT_NONE;
        end else if (h[2:1] == 2'h0) begin
            r[0] = 1'b0;
        end
        return r;
    endfunction

    function automatic tab_pkg::tab_attr_t f_fix(input tab_pkg::tab_attr_t a);
        tab_pkg::tab_attr_t r;
        r = a;
        if (a.dev != tab_pkg::DEV_NORMAL) begin
            r.sh = tab_pkg::SH_OSH;
            r.hi = tab_pkg::HINT_NONE;
            r.ho = tab_pkg::HINT_NONE;
        end else begin
            if (a.ic == tab_pkg::CACHE_NC && a.oc == tab_pkg::CACHE_NC) begin
                r.sh = tab_pkg::SH_OSH;
            end
            r.hi = f_lvl(a.ic, a.hi);
            r.ho = f_lvl(a.oc, a.ho);
        end
        return r;
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    logic [1:0]  ctrl_q;
    logic [31:0] gbpa_q;
    logic [31:0] sgbpa_q;
    logic [15:0] byp_cnt_q;
    logic [15:0] term_cnt_q;

    // ************************************************************
    // control selection and incoming defaults
    // ************************************************************
    wire        sec    = tab_pkg::SECURE_PRESENT & I_SEC_STREAM;
    wire        ctl_en = sec ? ctrl_q[tab_pkg::CTRL_SEN] : ctrl_q[tab_pkg::CTRL_EN];
    wire [31:0] g      = sec ? sgbpa_q : gbpa_q;
    wire        is_ats = (I_CLASS == tab_pkg::CLS_ATS_REQ) || (I_CLASS == tab_pkg::CLS_ATS_XLT);
    wire        term   = ~ctl_en & is_ats;
    wire        fwb_on = tab_pkg::FWB_SUPPORTED & I_S2_FWB & ~I_NO_SNOOP;

    // unsupplied attributes take the constructed defaults
    tab_pkg::tab_attr_t inc;
    assign inc.dev = I_SUPPLIED[tab_pkg::SUP_MT] ? I_DEV : tab_pkg::DEV_NORMAL;
    assign inc.ic  = I_SUPPLIED[tab_pkg::SUP_MT] ? I_ICACHE : tab_pkg::CACHE_WB;
    assign inc.oc  = I_SUPPLIED[tab_pkg::SUP_MT] ? I_OCACHE : tab_pkg::CACHE_WB;
    assign inc.sh  = I_SUPPLIED[tab_pkg::SUP_SH] ? I_SHARE : tab_pkg::SH_NSH;
    assign inc.hi  = I_SUPPLIED[tab_pkg::SUP_HINT] ? I_HINT_I : tab_pkg::HINT_DEF;
    assign inc.ho  = I_SUPPLIED[tab_pkg::SUP_HINT] ? I_HINT_O : tab_pkg::HINT_DEF;
    wire inc_inst  = I_SUPPLIED[tab_pkg::SUP_INST] & I_INSTR & ~I_WRITE;
    wire inc_access_level_marker  = I_SUPPLIED[tab_pkg::SUP_ACCESS_LEVEL_MARKER] & I_ACCESS_LEVEL_MARKER;
    wire inc_ns    = ~I_SUPPLIED[tab_pkg::SUP_NS] | I_NS;
    wire inc_cache = (inc.dev == tab_pkg::DEV_NORMAL) &&
                     !(inc.ic == tab_pkg::CACHE_NC && inc.oc == tab_pkg::CACHE_NC);

    // ************************************************************
    // bypass path
    // ************************************************************
    wire       mt_sel = g[tab_pkg::GB_MT_SEL];
    wire [6:0] mt_val = g[tab_pkg::GB_MT_VAL +: 7];
    wire [1:0] sh_ov  = g[tab_pkg::GB_SH +: 2];
    wire       hint_en = g[tab_pkg::GB_HINT_EN];
    wire [1:0] inst_ov = g[tab_pkg::GB_INST +: 2];
    wire [1:0] access_level_marker_ov = g[tab_pkg::GB_ACCESS_LEVEL_MARKER +: 2];
    wire [1:0] ns_ov   = g[tab_pkg::GB_NS +: 2];
    // a type made cacheable by override restarts from default hints
    wire [2:0] hint_in = (mt_sel && !inc_cache) ? tab_pkg::HINT_DEF : inc.hi;
    wire [2:0] hint_io = (mt_sel && !inc_cache) ? tab_pkg::HINT_DEF : inc.ho;
    // cache maintenance drops client hints so they cannot steer allocation
    wire       is_cmo  = (I_CLASS == tab_pkg::CLS_CMO);
    wire [2:0] hint_bi = is_cmo ? tab_pkg::HINT_DEF :
                         (hint_en ? g[tab_pkg::GB_HINT +: 3] : hint_in);
    wire [2:0] hint_bo = is_cmo ? tab_pkg::HINT_DEF :
                         (hint_en ? g[tab_pkg::GB_HINT +: 3] : hint_io);

    tab_pkg::tab_attr_t byp;
    assign byp.dev = mt_sel ? mt_val[6:4] : inc.dev;
    assign byp.ic  = mt_sel ? mt_val[3:2] : inc.ic;
    assign byp.oc  = mt_sel ? mt_val[1:0] : inc.oc;
    assign byp.sh  = (sh_ov == 2'h3) ? inc.sh : sh_ov;
    assign byp.hi  = hint_bi;
    assign byp.ho  = hint_bo;
    // code 2 forces 0, code 3 forces 1, else incoming; writes are always data
    wire byp_inst = ~I_WRITE & (inst_ov[1] ? inst_ov[0] : inc_inst);
    wire byp_access_level_marker = access_level_marker_ov[1] ? access_level_marker_ov[0] : inc_access_level_marker;
    wire byp_ns   = ~sec | (ns_ov[1] ? ns_ov[0] : inc_ns);

    // ************************************************************
    // translation path
    // ************************************************************
    tab_pkg::tab_attr_t s1a;
    tab_pkg::tab_attr_t s1c;
    tab_pkg::tab_attr_t s1m;
    tab_pkg::tab_attr_t s2b;
    tab_pkg::tab_attr_t src;
    tab_pkg::tab_attr_t s2c;
    tab_pkg::tab_attr_t s2f;
    tab_pkg::tab_attr_t xlt;
    assign s1a = '{dev: I_S1_DEV, ic: I_S1_ICACHE, oc: I_S1_OCACHE, sh: I_S1_SHARE,
                   hi: I_S1_HINT_I, ho: I_S1_HINT_O};
    assign s1c = f_comb(inc, s1a);
    // stage 1 replaces type and sharing; client hints survive only if cacheable
    assign s1m = '{dev: s1a.dev, ic: s1a.ic, oc: s1a.oc, sh: s1a.sh,
                   hi: inc_cache ? s1c.hi : s1a.hi, ho: inc_cache ? s1c.ho : s1a.ho};
    // stage 2 carries no hints: neutral defaults leave them as they are
    assign s2b = '{dev: I_S2_DEV, ic: I_S2_ICACHE, oc: I_S2_OCACHE, sh: I_S2_SHARE,
                   hi: tab_pkg::HINT_DEF, ho: tab_pkg::HINT_DEF};
    assign src = I_S1_EN ? s1m : inc;
    assign s2c = f_comb(src, s2b);
    assign s2f = '{dev: tab_pkg::DEV_NORMAL, ic: tab_pkg::CACHE_WB, oc: tab_pkg::CACHE_WB,
                   sh: (src.sh > tab_pkg::SH_ISH) ? src.sh : tab_pkg::SH_ISH,
                   hi: src.hi, ho: src.ho};
    // translation-op results use this same path, so they see the override too
    assign xlt = I_S2_EN ? (fwb_on ? s2f : s2c) : src;

    // ************************************************************
    // output selection and registers
    // ************************************************************
    tab_pkg::tab_attr_t fin;
    assign fin = f_fix(ctl_en ? xlt : byp);
    // permission markers bypass every merge and pass as resolved
    wire out_inst = ctl_en ? inc_inst : byp_inst;
    wire out_access_level_marker = ctl_en ? inc_access_level_marker : byp_access_level_marker;
    wire out_ns   = ctl_en ? (~sec | inc_ns) : byp_ns;

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_VALID     <= 1'b0;
            O_DEV       <= tab_pkg::DEV_NORMAL;
            O_ICACHE    <= tab_pkg::CACHE_WB;
            O_OCACHE    <= tab_pkg::CACHE_WB;
            O_SHARE     <= tab_pkg::SH_NSH;
            O_HINT_I    <= tab_pkg::HINT_NONE;
            O_HINT_O    <= tab_pkg::HINT_NONE;
            O_INSTR     <= 1'b0;
            O_ACCESS_LEVEL_MARKER      <= 1'b0;
            O_NS        <= 1'b1;
            O_BYPASS    <= 1'b0;
            O_TERMINATE <= 1'b0;
            O_XLATE     <= 1'b0;
            O_XLAT_OP   <= 1'b0;
        end else begin
            O_VALID     <= I_VALID;
            O_DEV       <= fin.dev;
            O_ICACHE    <= fin.ic;
            O_OCACHE    <= fin.oc;
            O_SHARE     <= fin.sh;
            O_HINT_I    <= fin.hi;
            O_HINT_O    <= fin.ho;
            O_INSTR     <= out_inst;
            O_ACCESS_LEVEL_MARKER      <= out_access_level_marker;
            O_NS        <= out_ns;
            O_BYPASS    <= I_VALID & ~ctl_en & ~term;
            O_TERMINATE <= I_VALID & term;
            O_XLATE     <= I_VALID & ctl_en;
            O_XLAT_OP   <= I_VALID & I_XLAT_OP;
        end
    end

    // ************************************************************
    // register port
    // ************************************************************
    wire wr_ctrl  = I_WR && (I_ADDR == tab_pkg::A_CTRL);
    wire wr_gbpa  = I_WR && (I_ADDR == tab_pkg::A_GBPA);
    wire wr_sgbpa = I_WR && (I_ADDR == tab_pkg::A_SGBPA) && tab_pkg::SECURE_PRESENT;
    wire [31:0] idr = {30'h0, tab_pkg::SECURE_PRESENT, tab_pkg::FWB_SUPPORTED};
    wire [31:0] rd_mux =
        (I_ADDR == tab_pkg::A_CTRL)  ? {30'h0, ctrl_q} :
        (I_ADDR == tab_pkg::A_GBPA)  ? gbpa_q :
        (I_ADDR == tab_pkg::A_SGBPA) ? sgbpa_q :
        (I_ADDR == tab_pkg::A_IDR)   ? idr :
        (I_ADDR == tab_pkg::A_STAT)  ? {term_cnt_q, byp_cnt_q} : 32'h0000_0000;

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            ctrl_q  <= tab_pkg::CTRL_RST;
            gbpa_q  <= tab_pkg::GBPA_RST;
            sgbpa_q <= tab_pkg::SECURE_PRESENT ? tab_pkg::SGBPA_RST : 32'h0000_0000;
            O_RDATA <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= I_WDATA[1:0];
            end
            if (wr_gbpa) begin
                gbpa_q <= I_WDATA & tab_pkg::GBPA_MASK;
            end
            if (wr_sgbpa) begin
                sgbpa_q <= I_WDATA & tab_pkg::GBPA_MASK;
            end
            O_RDATA <= I_RD ? rd_mux : 32'h0000_0000;
        end
    end

    // event counters wrap; software takes differences
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            byp_cnt_q  <= 16'h0000;
            term_cnt_q <= 16'h0000;
        end else begin
            byp_cnt_q  <= byp_cnt_q + 16'((I_VALID && !ctl_en && !term) ? 1 : 0);
            term_cnt_q <= term_cnt_q + 16'((I_VALID && term) ? 1 : 0);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);

    property p_dev_osh;
        O_VALID && (O_DEV != tab_pkg::DEV_NORMAL) |-> O_SHARE == tab_pkg::SH_OSH;
    endproperty
    a_dev_osh: assert property (p_dev_osh) else $error("device not outer shareable");

    property p_nc_hint;
        O_VALID && (O_DEV == tab_pkg::DEV_NORMAL) && (O_ICACHE == tab_pkg::CACHE_NC)
            |-> O_HINT_I == tab_pkg::HINT_NONE;
    endproperty
    a_nc_hint: assert property (p_nc_hint) else $error("noncached level has hints");

    property p_noalloc_ntr;
        O_VALID && (O_DEV == tab_pkg::DEV_NORMAL) && (O_OCACHE != tab_pkg::CACHE_NC)
            && (O_HINT_O[2:1] == 2'h0) |-> !O_HINT_O[0];
    endproperty
    a_noalloc_ntr: assert property (p_noalloc_ntr) else $error("transient without alloc");

    property p_ns_one;
        I_VALID && !sec |=> O_NS;
    endproperty
    a_ns_one: assert property (p_ns_one) else $error("non-secure stream lost marker");

    property p_ats_term;
        I_VALID && !ctl_en && is_ats |=> O_TERMINATE && !O_BYPASS && !O_XLATE;
    endproperty
    a_ats_term: assert property (p_ats_term) else $error("ATS not terminated");

    property p_xlate;
        I_VALID && ctl_en |=> O_XLATE && !O_BYPASS && !O_TERMINATE;
    endproperty
    a_xlate: assert property (p_xlate) else $error("translation flow not started");

    property p_s2_strong;
        I_VALID && ctl_en && I_S2_EN && !fwb_on |=> O_DEV >= $past(I_S2_DEV);
    endproperty
    a_s2_strong: assert property (p_s2_strong) else $error("merge weakened type");

    property p_fwb;
        I_VALID && ctl_en && I_S2_EN && fwb_on |=>
            (O_DEV == tab_pkg::DEV_NORMAL) && (O_ICACHE == tab_pkg::CACHE_WB)
            && (O_OCACHE == tab_pkg::CACHE_WB) && (O_SHARE != tab_pkg::SH_NSH);
    endproperty
    a_fwb: assert property (p_fwb) else $error("forced writeback not applied");

    property p_idr;
        I_RD && (I_ADDR == tab_pkg::A_IDR) |=>
            O_RDATA[tab_pkg::IDR_FWB] && (O_RDATA[31:2] == 30'h0000_0000);
    endproperty
    a_idr: assert property (p_idr) else $error("support bit wrong");

    property p_byp_write_data;
        I_VALID && !ctl_en && I_WRITE |=> !O_INSTR;
    endproperty
    a_byp_write_data: assert property (p_byp_write_data) else $error("write marked fetch");

endmodule

//--- tb/tab_sink.sv
`timescale 1ns/100ps
// ************************************************************
// downstream interconnect sink
// ************************************************************
module tab_sink (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    // outgoing beat
    input  wire logic               i_valid,
    input  wire tab_pkg::tab_attr_t i_attr,
    input  wire logic [6:0]         i_flg,
    // last accepted beat
    output tab_pkg::tab_attr_t      o_attr,
    output logic [6:0]              o_flg,
    output logic [7:0]              o_cnt
);
    // only beats marked valid are latched; idle cycles carry stale attributes
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_attr <= '0;
            o_flg  <= '0;
            o_cnt  <= 8'h00;
        end else if (i_valid) begin
            o_attr <= i_attr;
            o_flg  <= i_flg;
            o_cnt  <= o_cnt + 8'h01;
        end
    end
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
    // ************************************************************
    // signals
    // ************************************************************
    logic                I_CLK_SYS, I_RST, I_WR, I_RD, I_VALID, I_WRITE, I_INSTR, I_ACCESS_LEVEL_MARKER;
    logic                I_NS, I_SEC_STREAM, I_NO_SNOOP, I_XLAT_OP, I_S1_EN, I_S2_EN, I_S2_FWB;
    logic [7:0]          I_ADDR;
    logic [31:0]         I_WDATA, O_RDATA;
    tab_pkg::tab_class_t I_CLASS, cls;
    logic [5:0]          I_SUPPLIED, sup;
    logic [2:0]          I_DEV, I_HINT_I, I_HINT_O, I_S1_DEV, I_S1_HINT_I, I_S1_HINT_O, I_S2_DEV;
    logic [1:0]          I_ICACHE, I_OCACHE, I_SHARE, I_S1_ICACHE, I_S1_OCACHE, I_S1_SHARE;
    logic [1:0]          I_S2_ICACHE, I_S2_OCACHE, I_S2_SHARE, O_ICACHE, O_OCACHE, O_SHARE;
    logic [2:0]          O_DEV, O_HINT_I, O_HINT_O;
    logic                O_VALID, O_INSTR, O_ACCESS_LEVEL_MARKER, O_NS, O_BYPASS, O_TERMINATE, O_XLATE, O_XLAT_OP;
    tab_pkg::tab_attr_t  ia, s1a, s2a, p_attr;
    logic [6:0]          p_flg;
    logic [7:0]          p_cnt;
    logic                w, ins, prv, ns, sec, nsn, xop, e1, e2, fwb;
    int                  miscompares = 0, n_tests = 0, cyc = 0, n_fire = 0;

    tab_attr_unit uut (.*);
    tab_sink snk (
        .i_clk(I_CLK_SYS), .i_rst(I_RST), .i_valid(O_VALID),
        .i_attr({O_DEV, O_ICACHE, O_OCACHE, O_SHARE, O_HINT_I, O_HINT_O}),
        .i_flg({O_BYPASS, O_TERMINATE, O_XLATE, O_XLAT_OP, O_INSTR, O_ACCESS_LEVEL_MARKER, O_NS}),
        .o_attr(p_attr), .o_flg(p_flg), .o_cnt(p_cnt)
    );

    always #25 I_CLK_SYS = ~I_CLK_SYS;
    // the whole run needs under a hundred cycles; a hang is stopped and failed at cycle 3000
    always @(posedge I_CLK_SYS) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK_SYS);
        {I_ADDR, I_WDATA, I_WR} <= {a, d, 1'b1};
        @(posedge I_CLK_SYS);
        I_WR <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge I_CLK_SYS);
        {I_ADDR, I_RD} <= {a, 1'b1};
        @(posedge I_CLK_SYS);
        I_RD <= 1'b0;
        #1 chk(O_RDATA, exp, nm);
    endtask
    task automatic dflt();
        ia  = {3'h0, 2'h0, 2'h0, 2'h0, 3'h6, 3'h6};
        s1a = ia;
        s2a = ia;
        sup = 6'h3F;
        {w, ins, prv, ns, sec, nsn, xop, e1, e2, fwb} = 10'h000;
        cls = tab_pkg::CLS_PLAIN;
    endtask
    // one beat in, then wait until the sink has latched it
    task automatic fire();
        @(posedge I_CLK_SYS);
        {I_DEV, I_ICACHE, I_OCACHE, I_SHARE, I_HINT_I, I_HINT_O} <= ia;
        {I_S1_DEV, I_S1_ICACHE, I_S1_OCACHE, I_S1_SHARE, I_S1_HINT_I, I_S1_HINT_O} <= s1a;
        {I_S2_DEV, I_S2_ICACHE, I_S2_OCACHE, I_S2_SHARE} <= s2a[14:6];
        {I_WRITE, I_INSTR, I_ACCESS_LEVEL_MARKER, I_NS, I_SEC_STREAM} <= {w, ins, prv, ns, sec};
        {I_NO_SNOOP, I_XLAT_OP, I_S1_EN, I_S2_EN, I_S2_FWB} <= {nsn, xop, e1, e2, fwb};
        {I_SUPPLIED, I_CLASS, I_VALID} <= {sup, cls, 1'b1};
        @(posedge I_CLK_SYS);
        I_VALID <= 1'b0;
        n_fire++;
        @(posedge I_CLK_SYS);
        #1;
    endtask

    initial begin
        {I_CLK_SYS, I_RST, I_WR, I_RD, I_VALID, I_ADDR, I_WDATA} = {3'h2, 2'h0, 8'h00, 32'h0};
        dflt();
        repeat (3) @(posedge I_CLK_SYS);
        I_RST <= 1'b0;
        rdc(tab_pkg::A_IDR, 32'h0000_0003, "idr");
        rdc(tab_pkg::A_GBPA, 32'h0000_3000, "gbpa_rst");
        rdc(tab_pkg::A_SGBPA, 32'h0000_3000, "sgbpa_rst");
        rdc(8'h20, 32'h0, "unmapped");
        wr(tab_pkg::A_GBPA, 32'hFFFF_FFFF);
        rdc(tab_pkg::A_GBPA, 32'h03FF_37F1, "gbpa_mask");
        wr(tab_pkg::A_GBPA, 32'h0000_3000);
        fire();
        chk(p_flg, 7'h41, "byp_flags");
        chk(p_attr, ia, "byp_attr");
        ia.ic = 2'h2;
        ia.oc = 2'h2;
        xop = 1'b1;
        fire();
        chk(p_attr, {3'h0, 2'h2, 2'h2, 2'h2, 3'h0, 3'h0}, "nc_cleanup");
        chk(p_flg[3], 1'b1, "xop_flag");
        dflt();
        ia.hi = 3'h1;
        ia.oc = 2'h2;
        fire();
        chk(p_attr, {3'h0, 2'h0, 2'h2, 2'h0, 3'h0, 3'h0}, "hint_cleanup");
        ia = {3'h4, 2'h2, 2'h1, 2'h2, 3'h1, 3'h0};
        {sup, ins, prv} = {6'h00, 2'h3};
        fire();
        chk(p_attr, {3'h0, 2'h0, 2'h0, 2'h0, 3'h6, 3'h6}, "defaults");
        chk(p_flg, 7'h41, "def_markers");
        for (int k = 0; k < 4; k++) begin
            dflt();
            {ia.hi, ia.ho} = 6'h00;
            cls = tab_pkg::tab_class_t'(k);
            fire();
            chk(p_flg[5], (k == 1 || k == 2), "terminate");
            chk(p_attr[5:0], (k == 3) ? 6'h36 : 6'h00, "cmo_hints");
        end
        dflt();
        wr(tab_pkg::A_GBPA, 32'h0000_1301);
        fire();
        chk(p_attr, {3'h3, 2'h0, 2'h0, 2'h2, 3'h0, 3'h0}, "mt_override");
        wr(tab_pkg::A_GBPA, 32'h0000_1000);
        fire();
        chk(p_attr, {3'h0, 2'h0, 2'h0, 2'h1, 3'h6, 3'h6}, "sh_override");
        wr(tab_pkg::A_SGBPA, 32'h0200_3000);
        {sec, ns} = 2'h3;
        fire();
        chk(p_flg[0], 1'b0, "sec_ns");
        wr(tab_pkg::A_CTRL, 32'h0000_0001);
        fire();
        chk(p_flg[6:4], 3'h4, "sec_bypass");
        sec = 1'b0;
        fire();
        chk(p_flg[6:4], 3'h1, "ns_xlate");
        e2 = 1'b1;
        s2a.dev = tab_pkg::DEV_NGNRE;
        fire();
        chk(p_attr, {3'h3, 2'h0, 2'h0, 2'h2, 3'h0, 3'h0}, "s2_only");
        {e1, s1a.dev, s2a.dev} = {1'b1, tab_pkg::DEV_NGNRE, tab_pkg::DEV_NGNRNE};
        fire();
        chk(p_attr[14:12], 3'h4, "dev_merge");
        s1a = {3'h0, 2'h0, 2'h0, 2'h1, 3'h5, 3'h6};
        s2a = {3'h0, 2'h1, 2'h2, 2'h0, 3'h6, 3'h6};
        fire();
        chk(p_attr, {3'h0, 2'h1, 2'h2, 2'h1, 3'h5, 3'h0}, "merge");
        s1a = {3'h0, 2'h1, 2'h1, 2'h1, 3'h6, 3'h6};
        s2a = {3'h0, 2'h0, 2'h0, 2'h1, 3'h6, 3'h6};
        {fwb, xop} = 2'h3;
        fire();
        chk(p_attr[14:6], {3'h0, 2'h0, 2'h0, 2'h1}, "fwb_xop");
        {nsn, xop} = 2'h2;
        fire();
        chk(p_attr[11:8], 4'h5, "fwb_nosnoop");
        dflt();
        {w, ins, prv} = 3'h7;
        fire();
        chk(p_flg[2:0], 3'h3, "markers");
        chk(p_cnt, n_fire, "beats");
        tally_and_finish();
    end
endmodule
